// *** hdl/pbsp_burst_ctr.sv ***
`timescale 1ns/100ps
module pbsp_burst_ctr (
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  input  wire logic       load_in,
  input  wire logic [1:0] start_in,
  input  wire logic       step_in,
  input  wire logic       interleave_in,
  output logic      [1:0] low_bits_out
);
  logic [1:0] start_q;
  logic [1:0] count_q;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      start_q <= 2'h0;
      count_q <= 2'h0;
    end else if (ce_in) begin
      if (load_in) begin
        start_q <= start_in;
        count_q <= 2'h0;
      end else if (step_in) begin
        count_q <= count_q + 2'h1; // wraps after four
      end
    end
  end

  always_comb begin
    if (interleave_in)
      low_bits_out = start_q ^ count_q;
    else
      low_bits_out = start_q + count_q;
  end
endmodule : pbsp_burst_ctr

// *** hdl/pbsp_pkg.sv ***
`include "pbsp_regs.svh"
package pbsp_pkg;
  typedef logic [`PBSP_LANES*`PBSP_LANE_W-1:0] pbsp_word_t;
  typedef logic [`PBSP_ADDR_W-1:0]             pbsp_addr_t;
  typedef struct packed {
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [`PBSP_LANES-1:0] lane_write_strobe_n;
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
  } pbsp_ctrl_t;
  typedef enum logic {
    PBSP_OP_READ,
    PBSP_OP_WRITE
  } pbsp_op_t;
endpackage : pbsp_pkg

// *** hdl/pbsp_regs.svh ***
`ifndef PBSP_REGS_SVH
`define PBSP_REGS_SVH
`define PBSP_ADDR_W      15
`define PBSP_LANES       4
`define PBSP_LANE_W      8
`define PBSP_WAKE_CYCLES 2
`define PBSP_WAKE_CNT_W  2
`endif

// *** hdl/pbsp_sram_port.sv ***
`timescale 1ns/100ps
`include "pbsp_regs.svh"
// What this block does
// - inputs registered on rising edge except output enable and sleep
// - sleep high freezes all state except the wake counter, and array contents
// - after sleep drops, operation resumes only after two wake cycles
// - processor strobe low with chip selected loads address, starts read
// - read data goes array to data-out register, then output buffer
// - burst step ignored on edge taking processor strobe
// - read burst advances with lane strobes high and step low
// - first chip select high blocks processor strobe
// - global write writes all lanes; else byte enable with lane strobes
// - lane strobes ignored on edge taking processor strobe
// - any lane strobe sampled low disables output buffers
// - lane strobes low capture data bus into input register
// - write burst advances with lane strobes and step low
// - each lane strobe controls one byte lane
// - controller start samples lane strobes on the starting edge
// - burst starts at external address, 2-bit counter wraps after four
// - order select low linear, high interleaved, static level
// - interleaved order xors start bits with step count
// - linear order adds step count to start bits modulo four
// - read right after write returns just-written data
module pbsp_sram_port #(
  parameter int ADDR_W = `PBSP_ADDR_W
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 srst_in,
  input  wire logic                 ce_in,
  input  wire pbsp_pkg::pbsp_ctrl_t ctrl_in,
  input  wire pbsp_pkg::pbsp_addr_t addr_in,
  input  wire logic                 linear_order_sel_n_in,
  input  wire logic                 output_drive_n_in,
  input  wire logic                 sleep_req_in,
  input  wire pbsp_pkg::pbsp_word_t data_in,
  output pbsp_pkg::pbsp_word_t      data_out,
  output logic [`PBSP_LANES-1:0]    data_oe_out,
  output logic                      awake_out
);
  import pbsp_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int LW    = `PBSP_LANE_W;

  // the address type is fixed by the package, and the burst needs two low bits
  if (ADDR_W != `PBSP_ADDR_W || ADDR_W < 2) begin : g_bad_addr_w
    $error("pbsp_sram_port: address width must match the package");
  end

  pbsp_word_t                mem [DEPTH];
  logic [`PBSP_WAKE_CNT_W-1:0] wake_q;
  logic        run;
  logic        sel;
  logic        start_proc;
  logic        start_ctrl;
  logic        desel;
  logic        lanes_low;
  logic [`PBSP_LANES-1:0] wr_lanes;
  logic        step_rd;
  logic        step_wr;
  logic        burst_step;
  logic        load;
  logic [1:0]  low_bits;
  logic [1:0]  step_bits;
  pbsp_addr_t  base_q;
  pbsp_addr_t  cur_addr;
  logic        active_q;
  logic        rd_now;
  logic        rd_s1_q;
  logic        rd_s2_q;
  pbsp_word_t  dout_reg_q;
  pbsp_word_t  out_buf_q;
  logic        wr_blank_q;
  pbsp_addr_t  wr_addr_q;
  pbsp_word_t  wr_data_q;
  logic [`PBSP_LANES-1:0] wr_mask_q;
  logic        wr_pend_q;

  // sleep acts without the clock: it directly gates every update except the wake counter load
  assign run = ce_in && !sleep_req_in && (wake_q == '0);
  assign sel = !ctrl_in.chip_select_first_n && ctrl_in.chip_select_second
               && !ctrl_in.chip_select_third_n;
  // first chip select high masks the processor strobe
  assign start_proc = !ctrl_in.proc_addr_strobe_n && sel;
  assign start_ctrl = ctrl_in.proc_addr_strobe_n && !ctrl_in.ctrl_addr_strobe_n && sel;
  // controller strobe with first select high deselects too; processor strobe there is ignored
  assign desel = (ctrl_in.chip_select_first_n && !ctrl_in.ctrl_addr_strobe_n)
                 || (!ctrl_in.chip_select_first_n && !sel
                     && !(ctrl_in.proc_addr_strobe_n && ctrl_in.ctrl_addr_strobe_n));
  assign load = start_proc || start_ctrl;

  // lane strobes unseen on a processor-strobe edge
  always_comb begin
    wr_lanes = '0;
    if (!start_proc && (active_q || start_ctrl)) begin
      if (!ctrl_in.global_write_n)
        wr_lanes = '1;
      else if (!ctrl_in.byte_write_enable_n)
        wr_lanes = ~ctrl_in.lane_write_strobe_n;
    end
  end
  assign lanes_low = |wr_lanes;

  // burst step ignored on start edges, taken on any other edge of an active burst
  assign step_rd = !lanes_low && !ctrl_in.burst_step_n;
  assign step_wr = lanes_low && !ctrl_in.burst_step_n;
  // step high with no new strobe holds address
  assign burst_step = !load && active_q && (step_rd || step_wr);

  pbsp_burst_ctr u_ctr (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .ce_in         (run),
    .load_in       (load),
    .start_in      (addr_in[1:0]),
    .step_in       (burst_step),
    .interleave_in (linear_order_sel_n_in),
    .low_bits_out  (low_bits)
  );

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wake_q <= '0;
    end else if (ce_in) begin
      if (sleep_req_in)
        wake_q <= `PBSP_WAKE_CNT_W'(`PBSP_WAKE_CYCLES);
      else if (wake_q != '0)
        wake_q <= wake_q - `PBSP_WAKE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      base_q   <= '0;
      active_q <= 1'b0;
    end else if (run) begin
      if (load) begin
        base_q   <= addr_in;
        active_q <= 1'b1;
      end else if (desel) begin
        active_q <= 1'b0;
      end
    end
  end

  // the address in use this edge: a new base on start, the stepped word on an
  // advance edge (that edge already accesses the next word), else the counter
  assign step_bits = linear_order_sel_n_in ? (base_q[1:0] ^ ((low_bits ^ base_q[1:0]) + 2'h1))
                                           : (low_bits + 2'h1);
  assign cur_addr  = load ? addr_in : {base_q[ADDR_W-1:2], burst_step ? step_bits : low_bits};
  assign rd_now   = run && (load ? !(start_ctrl && lanes_low) : (active_q && !lanes_low));

  // late write: data lands in the array one edge after it is captured
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_mask_q <= '0;
    end else if (run) begin
      wr_pend_q <= lanes_low;
      if (lanes_low) begin
        wr_addr_q <= cur_addr;
        wr_data_q <= data_in;
        wr_mask_q <= wr_lanes;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (run && wr_pend_q) begin
      for (int i = 0; i < `PBSP_LANES; i++) begin
        if (wr_mask_q[i])
          mem[wr_addr_q][i*LW +: LW] <= wr_data_q[i*LW +: LW];
      end
    end
  end

  // two-stage read path with bypass of a pending write
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      dout_reg_q <= '0;
      out_buf_q  <= '0;
      rd_s1_q    <= 1'b0;
      rd_s2_q    <= 1'b0;
      wr_blank_q <= 1'b0;
    end else if (run) begin
      rd_s1_q    <= rd_now;
      rd_s2_q    <= rd_s1_q;
      out_buf_q  <= dout_reg_q;
      wr_blank_q <= lanes_low;
      if (rd_now) begin
        for (int i = 0; i < `PBSP_LANES; i++) begin
          if (wr_pend_q && wr_mask_q[i] && wr_addr_q == cur_addr)
            dout_reg_q[i*LW +: LW] <= wr_data_q[i*LW +: LW];
          else
            dout_reg_q[i*LW +: LW] <= mem[cur_addr][i*LW +: LW];
        end
      end
    end
  end

  assign data_out    = out_buf_q;
  // drive is asynchronous on output enable and sleep
  assign data_oe_out = {`PBSP_LANES{rd_s2_q && !wr_blank_q && !output_drive_n_in && !sleep_req_in}};
  assign awake_out   = run;

  property p_wake;
    @(posedge clk_sys_in) disable iff (srst_in)
      (ce_in && $fell(sleep_req_in)) |-> !awake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("woke too early");

  property p_freeze;
    @(posedge clk_sys_in) disable iff (srst_in)
      sleep_req_in |=> $stable(out_buf_q) && $stable(base_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state changed in sleep");

  sequence s_read_issue;
    run && rd_now;
  endsequence
  property p_pipe;
    @(posedge clk_sys_in) disable iff (srst_in)
      s_read_issue ##1 run |=> rd_s2_q;
  endproperty
  a_pipe: assert property (p_pipe) else $error("read pipeline depth wrong");

  property p_blank;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && lanes_low) |=> (data_oe_out == '0);
  endproperty
  a_blank: assert property (p_blank) else $error("drove bus after write");

  property p_gw;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && !ctrl_in.global_write_n && !start_proc && active_q) |=> wr_pend_q && (wr_mask_q == '1);
  endproperty
  a_gw: assert property (p_gw) else $error("global write missed lanes");

  property p_proc_no_write;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && start_proc) |=> !wr_pend_q && !wr_blank_q && (low_bits == $past(addr_in[1:0]));
  endproperty
  a_proc_no_write: assert property (p_proc_no_write) else $error("strobe edge sampled write or step");

  property p_hold;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && !load && ctrl_in.burst_step_n) |=> $stable(low_bits);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved on suspend");

  property p_cs1;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && ctrl_in.chip_select_first_n && ctrl_in.ctrl_addr_strobe_n && !active_q) |=> !active_q;
  endproperty
  a_cs1: assert property (p_cs1) else $error("started while first select high");

  property p_sleep_quiet;
    @(posedge clk_sys_in) disable iff (srst_in)
      sleep_req_in |-> (data_oe_out == '0);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("drove bus while asleep");

  property p_start_addr;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && load) |=> (base_q == $past(addr_in)) && (low_bits == $past(addr_in[1:0]));
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("burst not started at external address");

  sequence s_read_advance;
    run && !load && active_q && !lanes_low && !ctrl_in.burst_step_n;
  endsequence
  property p_read_advance;
    @(posedge clk_sys_in) disable iff (srst_in)
      s_read_advance |=> !$stable(low_bits);
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("read burst did not advance");

  sequence s_write_advance;
    run && !load && active_q && lanes_low && !ctrl_in.burst_step_n;
  endsequence
  property p_write_advance;
    @(posedge clk_sys_in) disable iff (srst_in)
      s_write_advance |=> !$stable(low_bits) && (wr_addr_q[1:0] == low_bits);
  endproperty
  a_write_advance: assert property (p_write_advance) else $error("write burst did not advance");

  property p_capture;
    @(posedge clk_sys_in) disable iff (srst_in)
      (run && lanes_low) |=> wr_pend_q && (wr_data_q == $past(data_in))
                             && (wr_mask_q == $past(wr_lanes));
  endproperty
  a_capture: assert property (p_capture) else $error("write data not captured");

  property p_bypass;
    @(posedge clk_sys_in) disable iff (srst_in)
      (rd_now && wr_pend_q && (wr_mask_q == '1) && (wr_addr_q == cur_addr))
        |=> (dout_reg_q == $past(wr_data_q));
  endproperty
  a_bypass: assert property (p_bypass) else $error("read after write missed new data");
endmodule : pbsp_sram_port

// *** sim/pbsp_host_model.sv ***
`timescale 1ns/100ps
module pbsp_host_model
  import pbsp_pkg::*;
(
  input  wire logic clk_sys_in,
  output pbsp_ctrl_t ctrl_out,
  output pbsp_addr_t addr_out,
  output pbsp_word_t wdata_out,
  output logic       drive_n_out
);
  // both strobes high, no step, no write, all selects active
  localparam pbsp_ctrl_t IDLE = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 4'hf, 1'h0, 1'h1, 1'h0};
  initial begin
    ctrl_out    = IDLE;
    addr_out    = '0;
    wdata_out   = '0;
    drive_n_out = 1'h0;
  end
  task automatic put(input pbsp_ctrl_t c, input pbsp_addr_t a, input pbsp_word_t d, input logic oe_n);
    @(negedge clk_sys_in);
    ctrl_out    = c;
    addr_out    = a;
    wdata_out   = d;
    drive_n_out = oe_n;
  endtask : put
  // unused address and data toggle so stale values never look valid
  task automatic idle();
    put(IDLE, ~addr_out, ~wdata_out, 1'h0);
  endtask : idle
  task automatic step();
    pbsp_ctrl_t c;
    c              = IDLE;
    c.burst_step_n = 1'h0;
    put(c, ~addr_out, ~wdata_out, 1'h0);
  endtask : step
  // strobes and step held low on purpose: the start edge must ignore them
  task automatic start_read(input pbsp_addr_t a);
    pbsp_ctrl_t c;
    c                     = IDLE;
    c.proc_addr_strobe_n  = 1'h0;
    c.burst_step_n        = 1'h0;
    c.lane_write_strobe_n = 4'h0;
    c.byte_write_enable_n = 1'h0;
    put(c, a, ~wdata_out, 1'h0);
  endtask : start_read
  task automatic write(input pbsp_addr_t a, input pbsp_word_t d, input logic [3:0] lanes_n, input logic gw_n);
    pbsp_ctrl_t c;
    c                     = IDLE;
    c.ctrl_addr_strobe_n  = 1'h0;
    c.global_write_n      = gw_n;
    c.byte_write_enable_n = 1'h0;
    c.lane_write_strobe_n = lanes_n;
    put(c, a, d, 1'h1);
  endtask : write
  // processor strobe with first select high: must be ignored, burst suspended
  task automatic blocked_start(input pbsp_addr_t a);
    pbsp_ctrl_t c;
    c                     = IDLE;
    c.proc_addr_strobe_n  = 1'h0;
    c.chip_select_first_n = 1'h1;
    put(c, a, ~wdata_out, 1'h0);
  endtask : blocked_start
  // one advance edge of a write burst on all lanes
  task automatic write_step(input pbsp_word_t d);
    pbsp_ctrl_t c;
    c                = IDLE;
    c.burst_step_n   = 1'h0;
    c.global_write_n = 1'h0;
    put(c, ~addr_out, d, 1'h1);
  endtask : write_step
endmodule : pbsp_host_model

// *** sim/tb.sv ***
`timescale 1ns/100ps
module tb;
  import pbsp_pkg::*;
  typedef struct packed {
    pbsp_addr_t a;
    pbsp_word_t d;
    logic [3:0] lanes_n;
    logic       gw_n;
    logic [3:0] oe_exp;
  } pbsp_row_t;
  logic       clk_sys_in;
  logic       srst_in;
  logic       ce_in;
  logic       order_n;
  logic       sleep_req;
  pbsp_ctrl_t ctrl;
  pbsp_addr_t addr;
  pbsp_word_t wdata;
  pbsp_word_t rdata;
  logic       drive_n;
  logic [3:0] oe;
  logic       awake;
  int         miscompares;
  int         checks;
  pbsp_word_t mem_m [16];
  // a row with no lane written is a read: its edge does not blank the bus, so the read of the idle edge before it drives
  pbsp_row_t  rows [6] = '{'{15'h2, 32'ha1a2a3a4, 4'he, 1'h1, 4'h0}, '{15'h3, 32'hb1b2b3b4, 4'hd, 1'h1, 4'h0},
                           '{15'h4, 32'hc1c2c3c4, 4'h3, 1'h1, 4'h0}, '{15'h5, 32'hd1d2d3d4, 4'h0, 1'h1, 4'h0},
                           '{15'h6, 32'he1e2e3e4, 4'hf, 1'h1, 4'hf}, '{15'h7, 32'hf1f2f3f4, 4'hf, 1'h0, 4'h0}};
  pbsp_host_model host (.clk_sys_in(clk_sys_in), .ctrl_out(ctrl), .addr_out(addr), .wdata_out(wdata),
                        .drive_n_out(drive_n));
  pbsp_sram_port dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in), .ctrl_in(ctrl), .addr_in(addr),
                      .linear_order_sel_n_in(order_n), .output_drive_n_in(drive_n), .sleep_req_in(sleep_req),
                      .data_in(wdata), .data_out(rdata), .data_oe_out(oe), .awake_out(awake));
  task automatic chk(input pbsp_word_t seen, input pbsp_word_t exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic burst(input pbsp_addr_t a, input int n);
    pbsp_addr_t x;
    host.start_read(a);
    for (int k = 0; k < n; k++) begin
      host.step();
      @(posedge clk_sys_in);
      #1;
      x      = a;
      x[1:0] = order_n ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
      chk(rdata, mem_m[x[3:0]]);
      chk(pbsp_word_t'(oe), 32'hf);
    end
    host.idle();
  endtask : burst
  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // whole run needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    miscompares++;
    end_sim();
  end
  initial begin
    srst_in     = 1'h1;
    ce_in       = 1'h1;
    order_n     = 1'h0;
    sleep_req   = 1'h0;
    miscompares = 0;
    checks      = 0;
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    srst_in = 1'h0;
    #1;
    chk(rdata, 32'h0);
    chk(pbsp_word_t'(oe), 32'h0);
    chk(pbsp_word_t'(awake), 32'h1);
    for (int i = 0; i < 10; i++) begin
      mem_m[i] = 32'h5a5a0000 | 32'(i);
      host.write(15'(i), mem_m[i], 4'hf, 1'h0);
    end
    foreach (rows[i]) begin
      host.write(rows[i].a, rows[i].d, rows[i].lanes_n, rows[i].gw_n);
      host.idle();
      #1;
      chk(pbsp_word_t'(oe), 32'(rows[i].oe_exp));
      for (int j = 0; j < 4; j++)
        if (!rows[i].gw_n || !rows[i].lanes_n[j]) mem_m[rows[i].a[3:0]][8*j +: 8] = rows[i].d[8*j +: 8];
    end
    for (int i = 0; i < 10; i++)
      burst(15'(i), 1);
    burst(15'h6, 5);
    order_n = 1'h1;
    burst(15'h5, 4);
    order_n = 1'h0;
    host.write(15'h9, 32'h9abcdef0, 4'h0, 1'h1);
    mem_m[9] = 32'h9abcdef0;
    burst(15'h9, 1);
    @(negedge clk_sys_in);
    sleep_req = 1'h1;
    #1;
    chk(pbsp_word_t'(awake), 32'h0);
    host.write(15'h2, 32'h0, 4'h0, 1'h0);
    host.idle();
    @(negedge clk_sys_in);
    sleep_req = 1'h0;
    @(posedge clk_sys_in);
    #1;
    chk(pbsp_word_t'(awake), 32'h0);
    @(posedge clk_sys_in);
    #1;
    chk(pbsp_word_t'(awake), 32'h1);
    // strobes held off two more clocks after wake-up
    host.idle();
    host.idle();
    burst(15'h2, 1);
    // write burst: start, then one advance edge on all lanes
    host.write(15'hc, 32'h11111111, 4'hf, 1'h0);
    host.write_step(32'h22222222);
    mem_m[12] = 32'h11111111;
    mem_m[13] = 32'h22222222;
    burst(15'hc, 2);
    // first select high: the strobe at 15'h8 must neither restart nor step the burst
    host.start_read(15'h4);
    host.blocked_start(15'h8);
    host.step();
    @(posedge clk_sys_in);
    #1;
    chk(rdata, mem_m[4]);
    host.step();
    @(posedge clk_sys_in);
    #1;
    chk(rdata, mem_m[5]);
    host.idle();
    end_sim();
  end
endmodule : tb
